/* File: verilog/gate_timing_pkg.sv */
// shared constants for the gate driver control timing block
package gate_timing_pkg;
  localparam int CLK_NS = 10;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // control field positions
  localparam int DGL_LSB = 0;
  localparam int DEAD_LSB = 2;
  localparam int MUTE_EN_BIT = 8;
  localparam int SV_LEVEL_BIT = 9;
  localparam int SEC_EN_BIT = 10;
  localparam int FB_SEL_LSB = 11;
  // status bit positions
  localparam int ST_DESATURATION_FAULT = 0;
  localparam int ST_SHUNT = 1;
  localparam int ST_OTEMP = 2;
  localparam int ST_RAIL = 3;
  localparam int ST_WARN = 4;
  localparam int ST_SV = 5;
  localparam int ST_START = 6;
  localparam int ST_W = 7;
  // times in ns (mute and start in ms), least times rounded up, longest rounded down
  localparam int DGL_STEP_NS = 70;
  localparam int DGL_STEP_CYC = (DGL_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_BASE_NS = 105;
  localparam int DEAD_BASE_CYC = (DEAD_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_STEP_NS = 70;
  localparam int DEAD_STEP_CYC = (DEAD_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SV_RISE_NS = 2000;
  localparam int SV_RISE_CYC = (SV_RISE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SV_FALL_NS = 100;
  localparam int SV_FALL_CYC = SV_FALL_NS / CLK_NS;
  localparam int SEC_RISE_NS = 1800;
  localparam int SEC_RISE_CYC = SEC_RISE_NS / CLK_NS;
  localparam int SEC_FALL_NS = 300;
  localparam int SEC_FALL_CYC = SEC_FALL_NS / CLK_NS;
  localparam int RAIL_DGL_NS = 30000;
  localparam int RAIL_DGL_CYC = RAIL_DGL_NS / CLK_NS;
  localparam int MUTE_MS = 10;
  localparam int MUTE_CYC = (MUTE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int START_MS = 5;
  localparam int START_CYC = START_MS * 1000000 / CLK_NS;
  localparam int FB_W = 10;
  localparam int DLY_W = 12;
endpackage

/* File: verilog/sync_filter.sv */
// two-flop synchroniser and stable-count deglitch, one lane per bit
`timescale 1ns/100ps
`default_nettype none
module sync_filter #(
  parameter int N = 1,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] din,
  input wire logic [CW-1:0] lim,
  output logic [N-1:0] dout
);
  logic [N-1:0] s1_reg;
  logic [N-1:0] s2_reg;
  logic [CW-1:0] cnt_reg [N];

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
    end
  end

  // a level must stand lim+1 cycles before it is accepted
  for (genvar i = 0; i < N; i++) begin : g_lane
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt_reg[i] <= '0;
        dout[i] <= 1'b0;
      end else if (s2_reg[i] == dout[i]) begin
        cnt_reg[i] <= '0;
      end else if (cnt_reg[i] >= lim) begin
        cnt_reg[i] <= '0;
        dout[i] <= s2_reg[i];
      end else begin
        cnt_reg[i] <= cnt_reg[i] + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/edge_delay.sv */
// level follower with separate rise and fall delays
`timescale 1ns/100ps
`default_nettype none
module edge_delay #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  input wire logic [W-1:0] rise_lim,
  input wire logic [W-1:0] fall_lim,
  output logic dout
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] lim;

  assign lim = din ? rise_lim : fall_lim;

  // a pulse shorter than the delay is swallowed, the counter restarts
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= lim) begin
      cnt_reg <= '0;
      dout <= din;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/gate_timing_ctrl.sv */
// gate driver control timing with ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - pwm change reaches gate output within 150 ns at deglitch zero.
// - alarm-class fault pulls alarm pin low within 5 us.
// - warning-class fault pulls warning pin low within 25 us.
// - primary short command acts 2 us after rise, 0.1 us after fall.
// - secondary short input acts 1.8 us after rise, 0.3 us after fall.
// - with muting on, pwm ignored 10 ms after severe switch faults.
// - primary control pins deglitched by 0, 70, 140 or 210 ns.
// - 6-bit dead time, zero none, 105 ns then 70 ns steps.
// - fault pins released high within 5 ms of power ready.
// - core rail overvoltage flagged only after 30 us persistence.
// - faults shown on open-drain pins, cause readable in status.
// - digital feedback output tracks one selected analog input.
// - primary and secondary short paths force the gate to the level in control bit 9.
module gate_timing_ctrl
  import gate_timing_pkg::*;
#(
  parameter int MUTE_CYCLES = MUTE_CYC,
  parameter int START_CYCLES = START_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pwm_in_pos,
  input wire logic short_vector_enable,
  input wire logic short_vector_cmd,
  input wire logic secondary_short_vector_input,
  input wire logic desaturation_fault,
  input wire logic shunt_short_fault,
  input wire logic switch_overtemp_fault,
  input wire logic primary_core_rail_ov,
  input wire logic secondary_core_rail_ov,
  input wire logic warning_fault,
  input wire logic power_ready,
  input wire logic alarm_out_n_i,
  output logic alarm_out_n_o,
  output logic alarm_out_n_oe,
  input wire logic warning_out_n_i,
  output logic warning_out_n_o,
  output logic warning_out_n_oe,
  input wire logic [FB_W-1:0] ai_sample,
  input wire logic [2:0] ai_chan,
  input wire logic ai_valid,
  output logic feedback_out,
  output logic gate_out,
  output logic irq
);
  logic [31:0] ctrl_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] evt;
  logic [ST_W-1:0] prev_reg;
  logic [ST_W-1:0] clr;
  logic [2:0] prim_f;
  logic [10:0] other_f;
  logic [4:0] dgl_lim;
  logic [5:0] dead_code;
  logic [DLY_W-1:0] dead_lim;
  logic pwm_f, sv_cmd_f, sv_en_f, sec_f, rail_any, rail_flag;
  logic sv_prim, sv_sec, sv_force, dly_out, alarm_live, severe;
  logic mute_reg, started_reg, wr_pend_reg, addr_ok;
  logic [31:0] mute_cnt_reg;
  logic [31:0] start_cnt_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_next;
  logic [FB_W-1:0] fb_hold_reg;
  logic [FB_W-1:0] fb_cnt_reg;

  assign dgl_lim = 5'(ctrl_reg[DGL_LSB +: 2]) * 5'(DGL_STEP_CYC);
  assign dead_code = ctrl_reg[DEAD_LSB +: 6];

  sync_filter #(.N(3), .CW(5)) u_prim (
    .clk(clk),
    .rst(rst),
    .din({pwm_in_pos, short_vector_cmd, short_vector_enable}),
    .lim(dgl_lim),
    .dout(prim_f)
  );
  // remaining pins only need two flops, no deglitch
  sync_filter #(.N(11), .CW(1)) u_other (
    .clk(clk),
    .rst(rst),
    .din({secondary_short_vector_input, desaturation_fault,
          shunt_short_fault, switch_overtemp_fault,
          primary_core_rail_ov, secondary_core_rail_ov, warning_fault,
          power_ready, alarm_out_n_i, warning_out_n_i, 1'b0}),
    .lim(1'b0),
    .dout(other_f)
  );
  assign pwm_f = prim_f[2];
  assign sv_cmd_f = prim_f[1];
  assign sv_en_f = prim_f[0];
  assign sec_f = other_f[10];
  assign rail_any = other_f[6] | other_f[5];

  // dead time steps of the code
  always_comb begin
    if (dead_code == 6'h00) begin
      dead_lim = '0;
    end else begin
      dead_lim = DLY_W'(DEAD_BASE_CYC)
        + DLY_W'(dead_code - 6'h01) * DLY_W'(DEAD_STEP_CYC);
    end
  end

  // only turn-on is delayed, turn-off passes at once
  edge_delay #(.W(DLY_W)) u_dead (
    .clk(clk),
    .rst(rst),
    .din(pwm_f),
    .rise_lim(dead_lim),
    .fall_lim('0),
    .dout(dly_out)
  );
  edge_delay #(.W(DLY_W)) u_sv_prim (
    .clk(clk),
    .rst(rst),
    .din(sv_cmd_f & sv_en_f),
    .rise_lim(DLY_W'(SV_RISE_CYC)),
    .fall_lim(DLY_W'(SV_FALL_CYC)),
    .dout(sv_prim)
  );
  edge_delay #(.W(DLY_W)) u_sv_sec (
    .clk(clk),
    .rst(rst),
    .din(sec_f & ctrl_reg[SEC_EN_BIT]),
    .rise_lim(DLY_W'(SEC_RISE_CYC)),
    .fall_lim(DLY_W'(SEC_FALL_CYC)),
    .dout(sv_sec)
  );
  edge_delay #(.W(DLY_W)) u_rail (
    .clk(clk),
    .rst(rst),
    .din(rail_any),
    .rise_lim(DLY_W'(RAIL_DGL_CYC)),
    .fall_lim('0),
    .dout(rail_flag)
  );

  assign sv_force = sv_prim | sv_sec;
  assign severe = other_f[9] | other_f[8] | other_f[7];
  assign alarm_live = severe | rail_flag;

  assign evt[ST_DESATURATION_FAULT] = other_f[9] & ~prev_reg[ST_DESATURATION_FAULT];
  assign evt[ST_SHUNT] = other_f[8] & ~prev_reg[ST_SHUNT];
  assign evt[ST_OTEMP] = other_f[7] & ~prev_reg[ST_OTEMP];
  assign evt[ST_RAIL] = rail_flag & ~prev_reg[ST_RAIL];
  assign evt[ST_WARN] = other_f[4] & ~prev_reg[ST_WARN];
  assign evt[ST_SV] = sv_force & ~prev_reg[ST_SV];
  assign evt[ST_START] = started_reg & ~prev_reg[ST_START];

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= {started_reg, sv_force, other_f[4], rail_flag,
                   other_f[7], other_f[8], other_f[9]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !other_f[3]) begin
      start_cnt_reg <= '0;
      started_reg <= 1'b0;
    end else if (start_cnt_reg >= 32'(START_CYCLES - 1)) begin
      started_reg <= 1'b1;
    end else begin
      start_cnt_reg <= start_cnt_reg + 32'h0000_0001;
    end
  end

  // mute restarts on every new severe fault
  always_ff @(posedge clk) begin
    if (rst) begin
      mute_reg <= 1'b0;
      mute_cnt_reg <= '0;
    end else if (ctrl_reg[MUTE_EN_BIT] && |evt[ST_OTEMP:ST_DESATURATION_FAULT]) begin
      mute_reg <= 1'b1;
      mute_cnt_reg <= 32'(MUTE_CYCLES - 1);
    end else if (mute_cnt_reg != 32'h0000_0000) begin
      mute_cnt_reg <= mute_cnt_reg - 32'h0000_0001;
    end else begin
      mute_reg <= 1'b0;
    end
  end

  // one register after the filter keeps latency short
  always_ff @(posedge clk) begin
    if (rst || !started_reg) begin
      gate_out <= 1'b0;
    end else if (sv_force) begin
      gate_out <= ctrl_reg[SV_LEVEL_BIT];
    end else begin
      gate_out <= dly_out & ~mute_reg & ~alarm_live;
    end
  end

  // alarm pin low while cause latched or live
  // warning pin likewise; pins held low until start-up ends
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_out_n_oe <= 1'b1;
      warning_out_n_oe <= 1'b1;
      alarm_out_n_o <= 1'b0;
      warning_out_n_o <= 1'b0;
    end else begin
      alarm_out_n_oe <= ~started_reg | alarm_live
        | (|status_reg[ST_RAIL:ST_DESATURATION_FAULT]);
      warning_out_n_oe <= ~started_reg | other_f[4] | status_reg[ST_WARN];
      alarm_out_n_o <= 1'b0;
      warning_out_n_o <= 1'b0;
    end
  end

  // pwm-coded copy of the selected channel
  always_ff @(posedge clk) begin
    if (rst) begin
      fb_hold_reg <= '0;
      fb_cnt_reg <= '0;
      feedback_out <= 1'b0;
    end else begin
      if (ai_valid && ai_chan == ctrl_reg[FB_SEL_LSB +: 3]) begin
        fb_hold_reg <= ai_sample;
      end
      fb_cnt_reg <= fb_cnt_reg + 1'b1;
      feedback_out <= fb_cnt_reg < fb_hold_reg;
    end
  end

  // ahb-lite slave, zero wait states
  assign addr_ok = haddr[1:0] == 2'b00;

  always_comb begin
    if (!addr_ok) begin
      rd_next = '0;
    end else if (haddr[7:0] == CTRL_OFS) begin
      rd_next = ctrl_reg;
    end else if (haddr[7:0] == STATUS_OFS) begin
      rd_next = 32'(status_reg);
    end else if (haddr[7:0] == MASK_OFS) begin
      rd_next = 32'(mask_reg);
    end else if (haddr[7:0] == STATE_OFS) begin
      rd_next = 32'({other_f[1], other_f[2], started_reg, mute_reg,
                     sv_force, gate_out});
    end else begin
      rd_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      wr_pend_reg <= hsel & htrans[1] & hwrite & addr_ok;
      wr_addr_reg <= haddr[7:0];
      hrdata <= (hsel & htrans[1] & ~hwrite) ? rd_next : 32'h0000_0000;
    end
  end

  assign clr = (wr_pend_reg && wr_addr_reg == STATUS_OFS)
    ? hwdata[ST_W-1:0] : '0;

  // cause kept until written one; a new event beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clr) | evt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= '0;
    end else if (wr_pend_reg && wr_addr_reg == CTRL_OFS) begin
      ctrl_reg <= {18'h00000, hwdata[13:0]};
    end else if (wr_pend_reg && wr_addr_reg == MASK_OFS) begin
      mask_reg <= hwdata[ST_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // one clock domain, so the checks share one clock and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_alarm;
    $rose(alarm_live) && started_reg |-> ##1 alarm_out_n_oe;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pin late");
  property p_warn;
    $rose(other_f[4]) |-> ##1 warning_out_n_oe[*2];
  endproperty
  a_warn: assert property (p_warn) else $error("warning pin late");
  property p_mute;
    mute_reg && !sv_force |=> !gate_out;
  endproperty
  a_mute: assert property (p_mute) else $error("pwm passed mute");
  property p_start;
    !started_reg |=> alarm_out_n_oe && warning_out_n_oe && !gate_out;
  endproperty
  a_start: assert property (p_start) else $error("released early");
  property p_dead;
    dead_code != 6'h00 && $rose(pwm_f) |-> !dly_out[*8];
  endproperty
  a_dead: assert property (p_dead) else $error("dead time short");
  property p_sv;
    $rose(sv_cmd_f & sv_en_f) |-> !sv_prim[*8];
  endproperty
  a_sv: assert property (p_sv) else $error("short path early");
  property p_sec;
    $rose(sec_f) && ctrl_reg[SEC_EN_BIT] |-> ##[1:200] sv_sec;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary short late");
  property p_rail;
    $rose(rail_any) |-> !rail_flag[*8];
  endproperty
  a_rail: assert property (p_rail) else $error("rail flag early");
  property p_irq;
    |(status_reg & mask_reg) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  c_gate: cover property (@(posedge clk) $rose(gate_out));
  c_mute: cover property (@(posedge clk) $rose(mute_reg));
  c_sv: cover property (@(posedge clk) $rose(sv_force));
  c_irq: cover property (@(posedge clk) $rose(irq));
endmodule
`default_nettype wire

/* File: tb/host_ctrl_model.sv */
// host controller model: pwm and short command pins, fault pin pull-ups
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model #(
  parameter int PWM_HALF = 1000,
  parameter int HOLD = 100
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_req,
  input wire logic sv_req,
  input wire logic alarm_oe,
  input wire logic alarm_o,
  input wire logic warning_oe,
  input wire logic warning_o,
  output logic pwm_in_pos,
  output logic short_vector_enable,
  output logic short_vector_cmd,
  output logic alarm_pin,
  output logic warning_pin
);
  int gap;
  int hold;
  assign alarm_pin = alarm_oe ? alarm_o : 1'b1;
  assign warning_pin = warning_oe ? warning_o : 1'b1;
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_in_pos <= 1'b0;
      gap <= 0;
    end else if (pwm_req != pwm_in_pos && gap >= PWM_HALF) begin
      pwm_in_pos <= pwm_req;
      gap <= 0;
    end else if (gap < PWM_HALF) begin
      gap <= gap + 1;
    end
  end
  // command hold time
  // enable leads on the way in and trails on the way out
  always_ff @(posedge clk) begin
    if (rst) begin
      short_vector_enable <= 1'b0;
      short_vector_cmd <= 1'b0;
      hold <= 0;
    end else if (hold < HOLD) begin
      hold <= hold + 1;
    end else if (sv_req && !short_vector_enable) begin
      short_vector_enable <= 1'b1;
      hold <= 0;
    end else if (sv_req != short_vector_cmd) begin
      short_vector_cmd <= sv_req;
      hold <= 0;
    end else if (!sv_req && short_vector_enable) begin
      short_vector_enable <= 1'b0;
      hold <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/gate_timing_ctrl_test.sv */
// self-checking bench for the gate driver control timing block
`timescale 1ns/100ps
`default_nettype none
module gate_timing_ctrl_test;
  import gate_timing_pkg::*;
  localparam int MUTE_N = 50;
  localparam int START_N = 20;
  localparam int LIMIT = 80000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] ai_sample = 10'h0;
  logic [2:0] ai_chan = 3'h0;
  logic ai_valid = 1'b0;
  logic pwm_req = 1'b0;
  logic sv_req = 1'b0;
  logic sec_in = 1'b0;
  logic pwr = 1'b0;
  logic warn_f = 1'b0;
  logic [2:0] sev = 3'h0;
  logic [1:0] rail = 2'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hreadyout, hresp, fb, gate, irq, a_o, a_oe, w_o, w_oe;
  logic a_pin, w_pin, pwm, sv_en, sv_cmd;
  wire logic [2:0] obs;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int e;
  int dgl_t [7] = '{0, 1, 2, 3, 0, 0, 0};
  int dead_t [7] = '{0, 0, 0, 0, 1, 2, 63};
  assign obs = {w_pin, a_pin, gate};

  gate_timing_ctrl #(.MUTE_CYCLES(MUTE_N), .START_CYCLES(START_N)) i_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pwm_in_pos(pwm), .short_vector_enable(sv_en),
    .short_vector_cmd(sv_cmd), .secondary_short_vector_input(sec_in),
    .desaturation_fault(sev[0]), .shunt_short_fault(sev[1]),
    .switch_overtemp_fault(sev[2]), .primary_core_rail_ov(rail[0]),
    .secondary_core_rail_ov(rail[1]), .warning_fault(warn_f),
    .power_ready(pwr), .alarm_out_n_i(a_pin), .alarm_out_n_o(a_o),
    .alarm_out_n_oe(a_oe), .warning_out_n_i(w_pin),
    .warning_out_n_o(w_o), .warning_out_n_oe(w_oe),
    .ai_sample(ai_sample), .ai_chan(ai_chan), .ai_valid(ai_valid),
    .feedback_out(fb), .gate_out(gate), .irq(irq));

  host_ctrl_model i_host (
    .clk(clk), .rst(rst), .pwm_req(pwm_req), .sv_req(sv_req),
    .alarm_oe(a_oe), .alarm_o(a_o), .warning_oe(w_oe), .warning_o(w_o),
    .pwm_in_pos(pwm), .short_vector_enable(sv_en),
    .short_vector_cmd(sv_cmd), .alarm_pin(a_pin), .warning_pin(w_pin));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hangs in the bus and pin waits are cut short here; wait_obs has its own per-wait limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk32(string nm, logic [31:0] ex, logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_in(string nm, int lo, int hi, int got);
    checks_done++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    repeat (25) @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wait_obs(int k, logic v, int lim);
    n = 0;
    while (obs[k] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic set_pwm(logic v, int lo, int hi);
    pwm_req <= v;
    do @(posedge clk); while (pwm !== v);
    wait_obs(0, v, hi + 5);
    chk_in("gate delay", lo, hi, n);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk32("bus idle", 32'h1, {30'h0, hresp, hreadyout});
    chk32("alarm before start", 32'h0, {31'h0, a_pin});
    bus(1'b0, CTRL_OFS, 32'h0);
    chk32("ctrl reset", CTRL_RST, q);
    bus(1'b0, 8'h10, 32'h0);
    chk32("unmapped", 32'h0, q);
    pwr <= 1'b1;
    wait_obs(1, 1'b1, START_N + 30);
    chk_in("start time", START_N, START_N + 10, n);
    chk32("warning after start", 32'h1, {31'h0, w_pin});
    bus(1'b0, STATUS_OFS, 32'h0);
    chk32("start flag", 32'h40, q & 32'h40);
    bus(1'b0, STATE_OFS, 32'h0);
    chk32("state word", 32'h38, q);
    $display("test startup done");
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, CTRL_OFS, {24'h0, 6'(dead_t[i]), 2'(dgl_t[i])});
      e = 7 * dgl_t[i];
      n = (dead_t[i] == 0) ? 0 : 11 + 7 * (dead_t[i] - 1);
      set_pwm(1'b1, e + n, e + n + 15);
      set_pwm(1'b0, e, e + 15);
    end
    $display("test pwm path done");
    // short vector drives the gate high against a low pwm
    bus(1'b1, CTRL_OFS, 32'h200);
    sv_req <= 1'b1;
    do @(posedge clk); while (sv_cmd !== 1'b1);
    wait_obs(0, 1'b1, 230);
    chk_in("primary rise", 200, 215, n);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk32("short flag", 32'h20, q & 32'h3F);
    sv_req <= 1'b0;
    do @(posedge clk); while (sv_cmd !== 1'b0);
    wait_obs(0, 1'b0, 40);
    chk_in("primary fall", 1, 25, n);
    bus(1'b1, CTRL_OFS, 32'h600);
    bus(1'b1, STATUS_OFS, 32'h20);
    sec_in <= 1'b1;
    wait_obs(0, 1'b1, 220);
    chk_in("secondary rise", 180, 195, n);
    sec_in <= 1'b0;
    wait_obs(0, 1'b0, 60);
    chk_in("secondary fall", 30, 45, n);
    bus(1'b1, STATUS_OFS, 32'h20);
    $display("test short vector done");
    bus(1'b1, CTRL_OFS, 32'h100);
    bus(1'b1, MASK_OFS, 32'h07);
    bus(1'b0, MASK_OFS, 32'h0);
    chk32("mask readback", 32'h07, q);
    set_pwm(1'b1, 0, 15);
    for (int f = 0; f < 3; f++) begin
      sev[f] <= 1'b1;
      repeat (3) @(posedge clk);
      sev <= 3'h0;
      wait_obs(1, 1'b0, 500);
      chk_in("alarm delay", 0, 499, n);
      wait_obs(0, 1'b1, MUTE_N + 60);
      chk_in("mute time", MUTE_N - 10, MUTE_N + 30, n);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk32("fault flag", 32'(1 << f), q & 32'h3F);
      chk32("irq raised", 32'h1, {31'h0, irq});
      bus(1'b1, STATUS_OFS, 32'(1 << f));
      repeat (4) @(posedge clk);
      chk32("irq cleared", 32'h0, {31'h0, irq});
      chk32("alarm released", 32'h1, {31'h0, a_pin});
    end
    $display("test severe faults done");
    warn_f <= 1'b1;
    wait_obs(2, 1'b0, 2500);
    chk_in("warning delay", 0, 2499, n);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk32("warning flag", 32'h10, q & 32'h3F);
    chk32("irq masked", 32'h0, {31'h0, irq});
    warn_f <= 1'b0;
    bus(1'b1, STATUS_OFS, 32'h10);
    repeat (4) @(posedge clk);
    chk32("warning released", 32'h1, {31'h0, w_pin});
    rail <= 2'h1;
    repeat (2000) @(posedge clk);
    rail <= 2'h0;
    bus(1'b0, STATUS_OFS, 32'h0);
    chk32("short rail pulse", 32'h0, q & 32'h08);
    rail <= 2'h2;
    wait_obs(1, 1'b0, 3100);
    chk_in("rail deglitch", 3000, 3020, n);
    rail <= 2'h0;
    bus(1'b1, STATUS_OFS, 32'h08);
    $display("test warning and rail done");
    bus(1'b1, CTRL_OFS, 32'h2800);
    ai_chan <= 3'h5;
    ai_sample <= 10'h100;
    ai_valid <= 1'b1;
    @(posedge clk);
    // a sample of another channel must not disturb the output
    ai_chan <= 3'h2;
    ai_sample <= 10'h3FF;
    @(posedge clk);
    ai_valid <= 1'b0;
    repeat (1100) @(posedge clk);
    n = 0;
    repeat (1024) begin
      @(posedge clk);
      if (fb === 1'b1) n++;
    end
    chk_in("feedback duty", 256, 256, n);
    $display("test feedback done");
    finish_test();
  end
endmodule
`default_nettype wire
